// ---- design/image_bank_mem.sv ----
`timescale 1ns/1ps
module image_bank_mem (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  image_mem_if.mem port
);
  // two banks of 128 bytes; one is filled while the other is read
  logic [7:0] store [0:255];
  logic [7:0] rd_data_q;

  // write port, no reset on the array itself
  always_ff @(posedge clk_i) begin
    if (ce_i && port.wr_en) begin
      store[{port.wr_bank, port.wr_addr}] <= port.wr_data;
    end
  end

  // registered read port so the image byte leaves from a flip-flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_q <= 8'h00;
    end else if (ce_i && port.rd_en) begin
      rd_data_q <= store[{port.rd_bank, port.rd_addr}];
    end
  end

  assign port.rd_data = rd_data_q;
endmodule : image_bank_mem

// ---- design/image_mem_if.sv ----
`timescale 1ns/1ps
interface image_mem_if;
  logic wr_en;
  logic wr_bank;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic rd_en;
  logic rd_bank;
  logic [6:0] rd_addr;
  logic [7:0] rd_data;

  modport mem (input wr_en, input wr_bank, input wr_addr, input wr_data,
               input rd_en, input rd_bank, input rd_addr, output rd_data);
  modport user (output wr_en, output wr_bank, output wr_addr, output wr_data,
                output rd_en, output rd_bank, output rd_addr, input rd_data);
endinterface : image_mem_if

// ---- design/motor_image_pkg.sv ----
package motor_image_pkg;

  // channel count and image geometry
  localparam int CHANNELS = 16;
  localparam int IMAGE_BYTES = 100;
  localparam logic [6:0] STATUS_FIRST = 7'h00;
  localparam logic [6:0] STATUS_LAST = 7'h1f;
  localparam logic [6:0] POS_FIRST = 7'h20;
  localparam logic [6:0] POS_LAST = 7'h5f;
  localparam logic [6:0] REMOTE_BYTE = 7'h60;
  localparam logic [6:0] IMAGE_LAST = 7'h63;
  localparam logic [6:0] FILL_LAST = 7'h7f;
  localparam int WORD_SHIFT = 2;

  // byte order inside one status group of four (odd channel first)
  localparam logic [1:0] GRP_ODD_SEC = 2'h0;
  localparam logic [1:0] GRP_ODD_PRI = 2'h1;
  localparam logic [1:0] GRP_EVEN_SEC = 2'h2;
  localparam logic [1:0] GRP_EVEN_PRI = 2'h3;

  // primary status byte fields
  localparam int PRI_SUDDEN_BIT = 7;
  localparam int PRI_DECEL_STOP_BIT = 6;
  localparam int PRI_LIMIT_STOP_BIT = 5;
  localparam int PRI_CMD_ERR_BIT = 4;
  localparam int PRI_DECEL_BIT = 3;
  localparam int PRI_ACCEL_BIT = 2;
  localparam int PRI_PULSE_BIT = 1;
  localparam int PRI_BUSY_BIT = 0;

  // secondary status byte fields
  localparam int SEC_CCW_MOVE_BIT = 7;
  localparam int SEC_CW_MOVE_BIT = 6;
  localparam int SEC_CCW_SOFT_BIT = 5;
  localparam int SEC_CW_SOFT_BIT = 4;
  localparam int SEC_HOLD_OFF_BIT = 3;
  localparam int SEC_HOME_BIT = 2;
  localparam int SEC_CCW_LIMIT_BIT = 1;
  localparam int SEC_CW_LIMIT_BIT = 0;
  localparam int REMOTE_BIT = 0;

  // wishbone register map, byte addresses
  localparam int WB_ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_COUNT = 8'h08;
  localparam logic [7:0] ADDR_PEEK_SEL = 8'h0c;
  localparam logic [7:0] ADDR_PEEK_DATA = 8'h10;

  localparam int CTRL_AUTO_BIT = 0;
  localparam int CTRL_CAPTURE_BIT = 1;
  localparam logic CTRL_AUTO_RESET = 1'b1;
  localparam int STAT_FILLING_BIT = 0;
  localparam int STAT_BANK_BIT = 1;
  localparam int STAT_VALID_BIT = 2;
  localparam int STAT_PENDING_BIT = 3;
  localparam int COUNT_DROP_LSB = 16;

  typedef logic [CHANNELS-1:0][7:0] byte_array_type;
  typedef logic [CHANNELS-1:0][31:0] pos_array_type;
  typedef enum logic {IDLE, FILL} fill_state_type;

endpackage : motor_image_pkg

// ---- design/motor_status_process_image.sv ----
// Behaviour
// - status, position and remote flag form the always-present cyclic image per exchange
// - the image is exactly 100 bytes, fields addressed by byte index from zero
// - bytes 0-31 hold status in pairs: odd secondary, odd primary, even secondary, even primary
// - positions of channels 0-15 fill bytes 32-95, four bytes each, low byte first
// - each position is a full-range signed 32-bit two's-complement count
// - primary byte: sudden, decel-stop, limit-stop end, cmd error, decel, accel, pulse, busy
//
// Added by the designer: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
module motor_status_process_image
  import motor_image_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // primary status flags, one bit per channel
  input wire logic [CHANNELS-1:0] sudden_stop_end_flag_i,
  input wire logic [CHANNELS-1:0] decel_stop_end_flag_i,
  input wire logic [CHANNELS-1:0] limit_stop_end_flag_i,
  input wire logic [CHANNELS-1:0] command_error_flag_i,
  input wire logic [CHANNELS-1:0] decelerating_flag_i,
  input wire logic [CHANNELS-1:0] accelerating_flag_i,
  input wire logic [CHANNELS-1:0] pulse_output_active_i,
  input wire logic [CHANNELS-1:0] busy_flag_i,
  // secondary status flags, one bit per channel
  input wire logic [CHANNELS-1:0] ccw_moving_i,
  input wire logic [CHANNELS-1:0] cw_moving_i,
  input wire logic [CHANNELS-1:0] counterclockwise_soft_limit_i,
  input wire logic [CHANNELS-1:0] clockwise_soft_limit_i,
  input wire logic [CHANNELS-1:0] hold_released_i,
  input wire logic [CHANNELS-1:0] home_limit_input_i,
  input wire logic [CHANNELS-1:0] counterclockwise_limit_input_i,
  input wire logic [CHANNELS-1:0] clockwise_limit_input_i,
  // signed position counts and remote mode
  input wire pos_array_type position_i,
  input wire logic remote_mode_i,
  // fieldbus side
  input wire logic exchange_start_i,
  input wire logic rd_en_i,
  input wire logic [6:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  output logic image_ready_o,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [WB_ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  // every flip-flop of the block outside u_mem lives in this one record
  typedef struct packed {
    fill_state_type state;
    logic [6:0] fill_idx;
    logic active_bank;
    logic valid;
    logic pending;
    logic auto_en;
    logic [15:0] count;
    logic [15:0] dropped;
    logic [6:0] peek_idx;
    byte_array_type prim;
    byte_array_type sec;
    pos_array_type pos;
    logic remote;
    logic ack;
    logic [31:0] dat;
    logic rd_valid;
    logic ready;
  } state_type;

  state_type q;
  state_type d;
  logic sw_capture;
  logic capture_req;
  byte_array_type prim_now;
  byte_array_type sec_now;

  // memory traffic travels through the interface, driven only from this module
  image_mem_if mif ();

  // one status byte: groups of four bytes cover channels 2k+1 then 2k
  function automatic logic [7:0] status_byte_at(input logic [6:0] idx, input byte_array_type prim,
                                                input byte_array_type sec);
    logic [3:0] ch;
    logic [7:0] b;
    ch = {idx[4:2], 1'b0};
    b = 8'h00;
    case (idx[1:0])
      GRP_ODD_SEC: b = sec[ch + 4'h1];
      GRP_ODD_PRI: b = prim[ch + 4'h1];
      GRP_EVEN_SEC: b = sec[ch];
      GRP_EVEN_PRI: b = prim[ch];
      default: b = 8'h00;
    endcase
    return b;
  endfunction : status_byte_at

  // one position byte: four per channel, bits 7:0 at the lowest address of the four
  // signed counts are copied bit for bit; two's complement needs no sign handling here
  function automatic logic [7:0] pos_byte_at(input logic [6:0] idx, input pos_array_type pos);
    logic [6:0] rel;
    logic [3:0] ch;
    logic [1:0] lane;
    rel = idx - POS_FIRST;
    ch = rel[5:2];
    lane = rel[1:0];
    return pos[ch][{lane, 3'b000} +: 8];
  endfunction : pos_byte_at

  // one byte of the image, picked from a frozen snapshot by its index
  function automatic logic [7:0] image_byte(input logic [6:0] idx, input byte_array_type prim,
                                            input byte_array_type sec, input pos_array_type pos,
                                            input logic remote);
    logic [7:0] b;
    b = 8'h00;
    if (idx <= STATUS_LAST) begin
      b = status_byte_at(idx, prim, sec);
    end else if (idx <= POS_LAST) begin
      b = pos_byte_at(idx, pos);
    end else if (idx == REMOTE_BYTE) begin
      b[REMOTE_BIT] = remote;
    end else if (idx <= IMAGE_LAST) begin
      b = 8'h00;
    end else begin
      // spare indices up to the bank end read zero as well, so any 7-bit read is defined
      b = 8'h00;
    end
    return b;
  endfunction : image_byte

  // register read mux; only the bits that exist are filled, the rest read zero
  function automatic logic [31:0] reg_read(input logic [WB_ADDR_W-1:0] adr, input state_type s);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (adr)
      ADDR_CTRL: w[CTRL_AUTO_BIT] = s.auto_en;
      ADDR_STATUS: begin
        w[STAT_FILLING_BIT] = (s.state == FILL);
        w[STAT_BANK_BIT] = s.active_bank;
        w[STAT_VALID_BIT] = s.valid;
        w[STAT_PENDING_BIT] = s.pending;
      end
      ADDR_COUNT: begin
        w[COUNT_DROP_LSB +: 16] = s.dropped;
        w[COUNT_DROP_LSB-1:0] = s.count;
      end
      ADDR_PEEK_SEL: w[6:0] = s.peek_idx;
      // software sees the snapshot that the current fill is built from
      ADDR_PEEK_DATA: w[7:0] = image_byte(s.peek_idx, s.prim, s.sec, s.pos, s.remote);
      // unmapped offsets still answer, with zero
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction : reg_read

  // pack the per-channel flags into the two status byte layouts
  always_comb begin
    prim_now = '0;
    sec_now = '0;
    for (int c = 0; c < CHANNELS; c++) begin
      prim_now[c][PRI_SUDDEN_BIT] = sudden_stop_end_flag_i[c];
      prim_now[c][PRI_DECEL_STOP_BIT] = decel_stop_end_flag_i[c];
      prim_now[c][PRI_LIMIT_STOP_BIT] = limit_stop_end_flag_i[c];
      prim_now[c][PRI_CMD_ERR_BIT] = command_error_flag_i[c];
      prim_now[c][PRI_DECEL_BIT] = decelerating_flag_i[c];
      prim_now[c][PRI_ACCEL_BIT] = accelerating_flag_i[c];
      prim_now[c][PRI_PULSE_BIT] = pulse_output_active_i[c];
      prim_now[c][PRI_BUSY_BIT] = busy_flag_i[c];
      sec_now[c][SEC_CCW_MOVE_BIT] = ccw_moving_i[c];
      sec_now[c][SEC_CW_MOVE_BIT] = cw_moving_i[c];
      sec_now[c][SEC_CCW_SOFT_BIT] = counterclockwise_soft_limit_i[c];
      sec_now[c][SEC_CW_SOFT_BIT] = clockwise_soft_limit_i[c];
      sec_now[c][SEC_HOLD_OFF_BIT] = hold_released_i[c];
      sec_now[c][SEC_HOME_BIT] = home_limit_input_i[c];
      sec_now[c][SEC_CCW_LIMIT_BIT] = counterclockwise_limit_input_i[c];
      sec_now[c][SEC_CW_LIMIT_BIT] = clockwise_limit_input_i[c];
    end
  end

  // next-state logic: bus slave, capture sequencer, read strobe
  always_comb begin
    d = q;
    sw_capture = 1'b0;
    d.ack = 1'b0;
    d.rd_valid = rd_en_i;

    // classic wishbone: ack one cycle after the strobe, dropped the cycle after
    if (wb_cyc_i && wb_stb_i && !q.ack) begin
      d.ack = 1'b1;
      d.dat = 32'h0000_0000;
      // writes to read-only or unmapped offsets are ignored but still acknowledged
      if (wb_we_i) begin
        case (wb_adr_i)
          ADDR_CTRL: begin
            if (wb_sel_i[0]) begin
              d.auto_en = wb_dat_i[CTRL_AUTO_BIT];
              sw_capture = wb_dat_i[CTRL_CAPTURE_BIT];
            end
          end
          ADDR_PEEK_SEL: begin
            if (wb_sel_i[0]) begin
              d.peek_idx = wb_dat_i[6:0];
            end
          end
          default: d.dat = 32'h0000_0000;
        endcase
      end else begin
        d.dat = reg_read(wb_adr_i, q);
      end
    end

    // each fieldbus exchange requests one sample of the machine, when enabled
    capture_req = (exchange_start_i && q.auto_en) || sw_capture;

    case (q.state)
      IDLE: begin
        if (capture_req || q.pending) begin
          // all fields frozen in the same cycle so nothing in the image is torn
          d.prim = prim_now;
          d.sec = sec_now;
          d.pos = position_i;
          d.remote = remote_mode_i;
          d.pending = 1'b0;
          // a fresh request meeting a pending one is served by the same snapshot, so it counts as dropped
          if (capture_req && q.pending) begin
            d.dropped = q.dropped + 16'h0001;
          end
          d.fill_idx = STATUS_FIRST;
          d.state = FILL;
        end
      end
      FILL: begin
        // a request during a fill waits; a second one is only counted
        // a request in the last fill cycle still sets pending: the set wins over the end of the fill
        // both counters wrap; software treats them as free-running
        if (capture_req) begin
          d.pending = 1'b1;
          if (q.pending) begin
            d.dropped = q.dropped + 16'h0001;
          end
        end
        if (q.fill_idx == FILL_LAST) begin
          // swap only after the back bank is complete, so readers never mix images
          d.active_bank = ~q.active_bank;
          d.valid = 1'b1;
          d.count = q.count + 16'h0001;
          d.state = IDLE;
        end else begin
          d.fill_idx = q.fill_idx + 7'h01;
        end
      end
      default: d.state = IDLE;
    endcase

    // taken from the next state so ready rises on the same edge as the bank swap
    d.ready = d.valid && (d.state == IDLE);
  end

  // all state in one register, frozen while the clock enable is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      // auto capture is on out of reset, so a master sees images with no software set-up
      q.auto_en <= CTRL_AUTO_RESET;
    end else if (ce_i) begin
      q <= d;
    end
  end

  // back bank is written from the snapshot, one byte per cycle
  assign mif.wr_en = (q.state == FILL);
  assign mif.wr_bank = ~q.active_bank;
  assign mif.wr_addr = q.fill_idx;
  // indices past the last image byte are written as zero as well
  assign mif.wr_data = image_byte(q.fill_idx, q.prim, q.sec, q.pos, q.remote);
  // fieldbus reads always come from the complete front bank
  assign mif.rd_en = rd_en_i;
  assign mif.rd_bank = q.active_bank;
  assign mif.rd_addr = rd_addr_i;

  image_bank_mem u_mem (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .port(mif.mem)
  );

  // outputs straight from registers
  // rd_data_o is the memory's own output register
  assign rd_data_o = mif.rd_data;
  assign rd_valid_o = q.rd_valid;
  assign image_ready_o = q.ready;
  assign wb_dat_o = q.dat;
  assign wb_ack_o = q.ack;

endmodule : motor_status_process_image

// ---- testbench/fieldbus_master_model.sv ----
`timescale 1ns/1ps
module fieldbus_master_model (
  input wire logic clk_i,
  input wire logic [7:0] rd_data_i,
  input wire logic rd_valid_i,
  output logic exchange_start_o,
  output logic rd_en_o,
  output logic [6:0] rd_addr_o
);
  logic [7:0] img [128];
  logic [6:0] taken_q;
  initial begin
    exchange_start_o = 1'b0;
    rd_en_o = 1'b0;
    rd_addr_o = 7'h7f;
  end
  // answer lags one cycle, so a byte belongs to the address taken the edge before
  always @(posedge clk_i) begin
    if (rd_en_o) taken_q <= rd_addr_o;
    if (rd_valid_i) img[taken_q] <= rd_data_i;
  end
  task automatic exchange();
    @(posedge clk_i);
    exchange_start_o <= 1'b1;
    @(posedge clk_i);
    exchange_start_o <= 1'b0;
  endtask : exchange
  // gap > 0 gives a slow master; idle address is inverted so stale values never pass
  task automatic read_image(input int gap);
    for (int i = 0; i < 100; i++) begin
      @(posedge clk_i);
      rd_en_o <= 1'b1;
      rd_addr_o <= 7'(i);
      repeat (gap) begin
        @(posedge clk_i);
        rd_en_o <= 1'b0;
        rd_addr_o <= ~7'(i);
      end
    end
    @(posedge clk_i);
    rd_en_o <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : read_image
endmodule : fieldbus_master_model

// ---- testbench/image_checker.sv ----
`timescale 1ns/1ps
module image_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic rd_en_i,
  input wire logic [6:0] rd_addr_i,
  input wire logic [7:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire logic image_ready_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a fill hides the image for the whole 128-index pass, then must return
  sequence s_fill_go; $fell(image_ready_o); endsequence
  sequence s_fill_busy; ##127 !image_ready_o; endsequence
  property p_fill_len; s_fill_go |-> s_fill_busy; endproperty
  a_fill_len: assert property (p_fill_len) else $error("image ready too early");
  property p_fill_end; s_fill_go |-> ##[128:600] image_ready_o; endproperty
  a_fill_end: assert property (p_fill_end) else $error("image never ready");
  property p_rd_lat; rd_en_i && ce_i |=> rd_valid_o; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read not answered");
  // a stray strobe would let the master latch a stale byte
  property p_rd_idle; !rd_en_i && ce_i |=> !rd_valid_o && $stable(rd_data_o); endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data moved idle");
  property p_unused; rd_valid_o && $past(image_ready_o) && $past(rd_addr_i) > 7'h60 |-> rd_data_o == 8'h00; endproperty
  a_unused: assert property (p_unused) else $error("unused byte not zero");
  property p_remote; rd_valid_o && $past(image_ready_o) && $past(rd_addr_i) == 7'h60 |-> rd_data_o[7:1] == 7'h00; endproperty
  a_remote: assert property (p_remote) else $error("remote byte spare bits set");
  property p_ack_take; wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o; endproperty
  a_ack_take: assert property (p_ack_take) else $error("bus not acknowledged");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than a cycle");
endmodule : image_checker
bind motor_status_process_image image_checker u_image_checker (.clk_i, .rst_i, .ce_i, .rd_en_i, .rd_addr_i,
  .rd_data_o, .rd_valid_o, .image_ready_o, .wb_cyc_i, .wb_stb_i, .wb_ack_o);

// ---- testbench/motor_status_process_image_bench.sv ----
`timescale 1ns/1ps
module motor_status_process_image_bench;
  import motor_image_pkg::*;
  logic clk_i;
  logic rst_i;
  logic [15:0] fl [16];
  logic [15:0] sfl [16];
  pos_array_type pos;
  pos_array_type spos;
  logic rem, srem, cyc, stb, we, wb_ack, ex_start, rd_en, rd_valid, ready, ce;
  logic [7:0] adr;
  logic [7:0] rd_data;
  logic [6:0] rd_addr;
  logic [31:0] wdat, rdat, wb_dat;
  int miscompares, total_checks, seed, images;
  motor_status_process_image u_motor_status_process_image (.clk_i, .rst_i, .ce_i(ce),
    .sudden_stop_end_flag_i(fl[0]), .decel_stop_end_flag_i(fl[1]), .limit_stop_end_flag_i(fl[2]),
    .command_error_flag_i(fl[3]), .decelerating_flag_i(fl[4]), .accelerating_flag_i(fl[5]),
    .pulse_output_active_i(fl[6]), .busy_flag_i(fl[7]), .ccw_moving_i(fl[8]), .cw_moving_i(fl[9]),
    .counterclockwise_soft_limit_i(fl[10]), .clockwise_soft_limit_i(fl[11]), .hold_released_i(fl[12]),
    .home_limit_input_i(fl[13]), .counterclockwise_limit_input_i(fl[14]), .clockwise_limit_input_i(fl[15]),
    .position_i(pos), .remote_mode_i(rem), .exchange_start_i(ex_start), .rd_en_i(rd_en), .rd_addr_i(rd_addr),
    .rd_data_o(rd_data), .rd_valid_o(rd_valid), .image_ready_o(ready), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hf), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack));
  fieldbus_master_model u_fieldbus_master_model (.clk_i, .rd_data_i(rd_data), .rd_valid_i(rd_valid),
    .exchange_start_o(ex_start), .rd_en_o(rd_en), .rd_addr_o(rd_addr));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  function automatic logic [7:0] stat_byte(input int c, input bit sec);
    logic [7:0] b;
    for (int j = 0; j < 8; j++) b[7 - j] = sfl[sec ? 8 + j : j][c];
    return b;
  endfunction : stat_byte
  // odd channel of each pair comes first in the status area
  function automatic logic [7:0] exp_byte(input int i);
    int c;
    c = (i < 32) ? (i / 4) * 2 + ((i % 4) < 2 ? 1 : 0) : (i - 32) / 4;
    if (i < 32) return stat_byte(c, (i % 2) == 0);
    if (i < 96) return spos[c][8 * (i % 4) +: 8];
    return (i == 96) ? {7'h00, srem} : 8'h00;
  endfunction : exp_byte
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude
  task automatic hang();
    miscompares++;
    conclude();
  endtask : hang
  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk_byte
  task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk_word
  // classic cycle: request held until the edge that samples ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (n >= 50) hang();
    rdat = wb_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ready !== 1'b1 && n < 400);
    if (n >= 400) hang();
  endtask : wait_ready
  // corner run pins every position to the two ends of the signed range
  task automatic shuffle(input bit corner);
    @(posedge clk_i);
    for (int j = 0; j < 16; j++) fl[j] <= 16'($random(seed));
    for (int c = 0; c < 16; c++) pos[c] <= corner ? (c[0] ? 32'h7fffffff : 32'h80000000) : $random(seed);
    rem <= 1'($random(seed));
  endtask : shuffle
  task automatic snap();
    sfl = fl;
    spos = pos;
    srem = rem;
  endtask : snap
  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, rem, adr, wdat, pos} = '0;
    ce = 1'b1;
    for (int j = 0; j < 16; j++) fl[j] = 16'h0000;
    seed = 32'ha0f49c59;
    {miscompares, total_checks, images} = '0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, ADDR_CTRL, 32'h0);
    chk_word("ctrl", 32'h1, rdat);
    wb(1'b0, ADDR_STATUS, 32'h0);
    chk_word("status", 32'h0, rdat);
    wb(1'b0, 8'h40, 32'h0);
    chk_word("unmapped", 32'h0, rdat);
    for (int k = 0; k < 4; k++) begin
      shuffle(k == 0);
      @(posedge clk_i);
      snap();
      u_fieldbus_master_model.exchange();
      shuffle(1'b0);
      wait_ready();
      // front bank flips once per finished image
      wb(1'b0, ADDR_STATUS, 32'h0);
      chk_word("status done", k[0] ? 32'h4 : 32'h6, rdat);
      images++;
      u_fieldbus_master_model.read_image(k % 2);
      for (int i = 0; i < 100; i++) chk_byte("image", exp_byte(i), u_fieldbus_master_model.img[i]);
    end
    // three requests: one runs, one waits, one is dropped
    repeat (3) u_fieldbus_master_model.exchange();
    images += 2;
    // mid-fill: filling, valid and pending set, front bank back at zero after four images
    wb(1'b0, ADDR_STATUS, 32'h0);
    chk_word("status busy", 32'hd, rdat);
    repeat (300) @(posedge clk_i);
    wb(1'b0, ADDR_COUNT, 32'h0);
    chk_word("count", {16'h0001, 16'(images)}, rdat);
    wb(1'b1, ADDR_CTRL, 32'h0);
    snap();
    u_fieldbus_master_model.exchange();
    repeat (3) @(posedge clk_i);
    chk_word("ready auto off", 32'h1, {31'h0, ready});
    wb(1'b1, ADDR_CTRL, 32'h2);
    // clock enable low stalls the fill, so the image must not appear while frozen
    ce <= 1'b0;
    repeat (200) @(posedge clk_i);
    chk_word("ready frozen", 32'h0, {31'h0, ready});
    ce <= 1'b1;
    wait_ready();
    for (int i = 92; i < 100; i++) begin
      wb(1'b1, ADDR_PEEK_SEL, 32'(i));
      wb(1'b0, ADDR_PEEK_DATA, 32'h0);
      chk_word("peek", {24'h0, exp_byte(i)}, rdat);
    end
    wb(1'b0, ADDR_PEEK_SEL, 32'h0);
    chk_word("peek sel", 32'h63, rdat);
    conclude();
  end
endmodule : motor_status_process_image_bench
